// file: core/pft_phy_timing.sv
// Media-independent side timing of a 10/100 transceiver: nibble clocks,
// transmit capture, carrier sense, receive delivery, link pulse bursts
// and strap capture at reset release.
// Assumes a 10 MHz core clock; MAC and strap pins are asynchronous to it.
//
// Overview of operation
// - Transmit clock 400 ns or 200 ns, even.
// - Receive clock 400 ns or 200 ns, even.
// - Transmit nibble and enable taken on rising edge.
// - Receive outputs change on receive clock rise.
// - 10M carrier sense 600 ns on, 1 us off.
// - 100M carrier sense follows enable after 100 ns.
// - Receive valid 7.2 us or 100 ns after carrier.
// - Link pulse bursts every 16 ms, about 2 ms.
// - Clock pulses 128 us apart, data at 64 us.
// - Pulses 100 ns wide, 17 to 33 per burst.
// - Straps loaded when reset is released.
`timescale 1ns/1ps
`default_nettype none

module pft_phy_timing #(
    parameter int unsigned    FLP_BTB_CYC = pft_pkg::PFT_FLP_BTB_CYC_DEF,
    parameter logic [15:0]    FLP_WORD    = pft_pkg::PFT_FLP_WORD_DEF
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Strap pins and the configuration latched from them.
    input  wire pft_pkg::pft_strap_s strap_pins,
    output var  pft_pkg::pft_strap_s cfg,
    output var  logic              cfg_loaded,
    // MAC interface.
    output var  logic              mii_txc,
    output var  logic              mii_rxc,
    input  wire pft_pkg::pft_tx_s  mii_tx,
    output var  pft_pkg::pft_rx_s  mii_rx,
    output var  logic              mii_crs,
    // Line side of the transmit and receive paths.
    output var  pft_pkg::pft_tx_s  line_tx,
    output var  logic              line_tx_stb,
    input  wire logic              line_rx_carrier,
    input  wire logic [3:0]        line_rx_data,
    input  wire logic              line_rx_err,
    // Link pulse output.
    output var  logic              flp_pulse
);
    import pft_pkg::*;

    // Strap capture.
    pft_strap_s strap_s1_q, strap_s2_q, cfg_q, cfg_d;
    logic [1:0] settle_q, settle_d;
    logic       loaded_q, loaded_d;

    // The synchroniser is given time to fill before its value is used,
    // so the captured straps never reflect the flops' reset value.
    always_comb begin
        cfg_d    = cfg_q;
        settle_d = settle_q;
        loaded_d = loaded_q;
        if (!loaded_q) begin
            if (settle_q == PFT_STRAP_SETTLE_CYC) begin
                cfg_d    = strap_s2_q;
                loaded_d = 1'b1;
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_s1_q <= '0;
            strap_s2_q <= '0;
            cfg_q      <= '0;
            settle_q   <= 2'h0;
            loaded_q   <= 1'b0;
        end else begin
            strap_s1_q <= strap_pins;
            strap_s2_q <= strap_s1_q;
            cfg_q      <= cfg_d;
            settle_q   <= settle_d;
            loaded_q   <= loaded_d;
        end
    end

    // Nibble clock generation.
    logic [1:0] phase_q, phase_d;
    logic [1:0] half;
    logic       txc_q, txc_d, rxc_q, rxc_d;
    logic       txc_rise, rxc_rise;

    // At this core rate the fast clock cannot reach 40 ns; it runs at the
    // shortest even-phase period that the core clock can make.
    always_comb begin
        half    = cfg_q.speed_100 ? PFT_HALF100_CYC : PFT_HALF10_CYC;
        phase_d = phase_q + 2'h1;
        txc_d   = txc_q;
        rxc_d   = rxc_q;
        if (phase_q >= half - 2'h1) begin
            phase_d = 2'h0;
            txc_d   = !txc_q;
            rxc_d   = !rxc_q;
        end
        txc_rise = !txc_q && txc_d;
        rxc_rise = !rxc_q && rxc_d;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 2'h0;
            txc_q   <= 1'b0;
            rxc_q   <= 1'b0;
        end else begin
            phase_q <= phase_d;
            txc_q   <= txc_d;
            rxc_q   <= rxc_d;
        end
    end

    // Transmit capture.
    pft_tx_s tx_s1_q, tx_s2_q, line_tx_q, line_tx_d;
    logic    tx_stb_q, tx_stb_d;

    always_comb begin
        line_tx_d = line_tx_q;
        tx_stb_d  = 1'b0;
        if (txc_rise) begin
            line_tx_d = tx_s2_q;
            tx_stb_d  = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_s1_q   <= '0;
            tx_s2_q   <= '0;
            line_tx_q <= '0;
            tx_stb_q  <= 1'b0;
        end else begin
            tx_s1_q   <= mii_tx;
            tx_s2_q   <= tx_s1_q;
            line_tx_q <= line_tx_d;
            tx_stb_q  <= tx_stb_d;
        end
    end

    // Carrier sense from transmit enable, merged with receive carrier.
    logic       crs_tx_q, crs_tx_d, crs_q, crs_d;
    logic [3:0] crs_cnt_q, crs_cnt_d;
    logic [3:0] crs_lat;

    always_comb begin
        if (cfg_q.speed_100) begin
            crs_lat = PFT_CRS_100_CYC;
        end else if (line_tx_q.en) begin
            crs_lat = PFT_CRS_ON10_CYC;
        end else begin
            crs_lat = PFT_CRS_OFF10_CYC;
        end
        crs_tx_d  = crs_tx_q;
        crs_cnt_d = 4'h0;
        if (line_tx_q.en != crs_tx_q) begin
            if (crs_cnt_q == crs_lat - 4'h1) begin
                crs_tx_d = line_tx_q.en;
            end else begin
                crs_cnt_d = crs_cnt_q + 4'h1;
            end
        end
        crs_d = crs_tx_d || line_rx_carrier;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crs_tx_q  <= 1'b0;
            crs_cnt_q <= 4'h0;
            crs_q     <= 1'b0;
        end else begin
            crs_tx_q  <= crs_tx_d;
            crs_cnt_q <= crs_cnt_d;
            crs_q     <= crs_d;
        end
    end

    // Receive delivery.
    logic [6:0] rx_cnt_q, rx_cnt_d;
    logic [6:0] rx_lat;
    logic       rx_ok_q, rx_ok_d;
    pft_rx_s    mii_rx_q, mii_rx_d;

    always_comb begin
        rx_lat   = cfg_q.speed_100 ? PFT_RXLAT100_CYC : PFT_RXLAT10_CYC;
        rx_cnt_d = rx_cnt_q;
        rx_ok_d  = rx_ok_q;
        if (!line_rx_carrier) begin
            rx_cnt_d = 7'h00;
            rx_ok_d  = 1'b0;
        end else if (!rx_ok_q) begin
            if (rx_cnt_q == rx_lat - 7'h01) begin
                rx_ok_d = 1'b1;
            end else begin
                rx_cnt_d = rx_cnt_q + 7'h01;
            end
        end
        mii_rx_d = mii_rx_q;
        if (rxc_rise) begin
            mii_rx_d.dv   = rx_ok_q && line_rx_carrier;
            mii_rx_d.er   = rx_ok_q && line_rx_carrier && line_rx_err;
            mii_rx_d.data = (rx_ok_q && line_rx_carrier) ? line_rx_data
                                                         : 4'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_cnt_q <= 7'h00;
            rx_ok_q  <= 1'b0;
            mii_rx_q <= '0;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_ok_q  <= rx_ok_d;
            mii_rx_q <= mii_rx_d;
        end
    end

    // Link pulse bursts while auto-negotiation is strapped on.
    pft_flp_e    flp_st_q, flp_st_d;
    logic [17:0] btb_q, btb_d;
    logic [10:0] slot_q, slot_d;
    logic [4:0]  idx_q, idx_d;
    logic        flp_q, flp_d;
    logic        data_slot;

    always_comb begin
        flp_st_d = flp_st_q;
        slot_d   = slot_q;
        idx_d    = idx_q;
        btb_d    = 18'h00000;
        if (cfg_q.an_en) begin
            btb_d = (btb_q == 18'(FLP_BTB_CYC - 1)) ? 18'h00000
                                                    : btb_q + 18'h00001;
        end
        case (flp_st_q)
            PFT_FLP_GAP: begin
                if (cfg_q.an_en && btb_q == 18'h00000) begin
                    flp_st_d = PFT_FLP_BURST;
                    slot_d   = 11'h000;
                    idx_d    = 5'h00;
                end
            end
            PFT_FLP_BURST: begin
                slot_d = slot_q + 11'h001;
                if (!cfg_q.an_en) begin
                    flp_st_d = PFT_FLP_GAP;
                end else if (idx_q == PFT_FLP_LAST_CLK &&
                             slot_q == PFT_FLP_CTD_CYC) begin
                    flp_st_d = PFT_FLP_GAP;
                end else if (slot_q == PFT_FLP_CTC_CYC - 11'h001) begin
                    slot_d = 11'h000;
                    idx_d  = idx_q + 5'h01;
                end
            end
            default: begin
                flp_st_d = PFT_FLP_GAP;
            end
        endcase
        // The last clock pulse carries no data pulse after it.
        data_slot = idx_q != PFT_FLP_LAST_CLK && FLP_WORD[idx_q[3:0]] &&
                    slot_q >= PFT_FLP_CTD_CYC &&
                    slot_q < PFT_FLP_CTD_CYC + PFT_FLP_PW_CYC;
        flp_d = flp_st_q == PFT_FLP_BURST && cfg_q.an_en &&
                (slot_q < PFT_FLP_PW_CYC || data_slot);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flp_st_q <= PFT_FLP_GAP;
            btb_q    <= 18'h00000;
            slot_q   <= 11'h000;
            idx_q    <= 5'h00;
            flp_q    <= 1'b0;
        end else begin
            flp_st_q <= flp_st_d;
            btb_q    <= btb_d;
            slot_q   <= slot_d;
            idx_q    <= idx_d;
            flp_q    <= flp_d;
        end
    end

    assign cfg         = cfg_q;
    assign cfg_loaded  = loaded_q;
    assign mii_txc     = txc_q;
    assign mii_rxc     = rxc_q;
    assign mii_rx      = mii_rx_q;
    assign mii_crs     = crs_q;
    assign line_tx     = line_tx_q;
    assign line_tx_stb = tx_stb_q;
    assign flp_pulse   = flp_q;

endmodule

`default_nettype wire

// file: core/pft_pkg.sv
// Package for the transceiver timing block: time figures, cycle counts,
// state codes and the packed signal groups shared by its ports.
// Assumes a single core clock of 10 MHz; every cycle count except the strap settle count derives from it.
package pft_pkg;

    localparam int PFT_CLK_NS = 100;

    // Longest or typical times round down, never below one cycle.
    function automatic int pft_cyc_floor(input int ns);
        int c;
        c = ns / PFT_CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Nibble clock periods in ns, split into equal phases.
    localparam int PFT_NCLK10_PERIOD_NS  = 400;
    localparam int PFT_NCLK100_PERIOD_NS = 40;
    localparam logic [1:0] PFT_HALF10_CYC =
        2'(pft_cyc_floor(PFT_NCLK10_PERIOD_NS / 2));
    localparam logic [1:0] PFT_HALF100_CYC =
        2'(pft_cyc_floor(PFT_NCLK100_PERIOD_NS / 2));

    // Carrier sense latencies from transmit enable, in ns.
    localparam int PFT_CRS_ON10_NS   = 600;
    localparam int PFT_CRS_OFF10_NS  = 1000;
    localparam int PFT_CRS_EDGE100_NS = 72;
    localparam logic [3:0] PFT_CRS_ON10_CYC  = 4'(pft_cyc_floor(PFT_CRS_ON10_NS));
    localparam logic [3:0] PFT_CRS_OFF10_CYC = 4'(pft_cyc_floor(PFT_CRS_OFF10_NS));
    localparam logic [3:0] PFT_CRS_100_CYC   =
        4'(pft_cyc_floor(PFT_CRS_EDGE100_NS));

    // Carrier sense to receive data valid latency, in ns.
    localparam int PFT_RXLAT10_NS  = 7200;
    localparam int PFT_RXLAT100_NS = 170;
    localparam logic [6:0] PFT_RXLAT10_CYC  = 7'(pft_cyc_floor(PFT_RXLAT10_NS));
    localparam logic [6:0] PFT_RXLAT100_CYC = 7'(pft_cyc_floor(PFT_RXLAT100_NS));

    // Link pulse burst timing.
    localparam int PFT_FLP_PW_NS  = 100;
    localparam int PFT_FLP_CTC_NS = 128000;
    localparam int PFT_FLP_CTD_NS = 64000;
    localparam int PFT_FLP_BTB_MS = 16;
    localparam logic [10:0] PFT_FLP_PW_CYC  = 11'(pft_cyc_floor(PFT_FLP_PW_NS));
    localparam logic [10:0] PFT_FLP_CTC_CYC = 11'(pft_cyc_floor(PFT_FLP_CTC_NS));
    localparam logic [10:0] PFT_FLP_CTD_CYC = 11'(pft_cyc_floor(PFT_FLP_CTD_NS));
    localparam int PFT_FLP_BTB_CYC_DEF  =
        pft_cyc_floor(PFT_FLP_BTB_MS * 1000000);
    localparam logic [4:0] PFT_FLP_LAST_CLK = 5'h10;
    localparam logic [15:0] PFT_FLP_WORD_DEF = 16'h0001;

    // Cycles the strap synchronisers need before their value is trusted.
    localparam logic [1:0] PFT_STRAP_SETTLE_CYC = 2'h2;

    typedef enum logic [1:0] {
        PFT_FLP_GAP   = 2'b01,
        PFT_FLP_BURST = 2'b10
    } pft_flp_e;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } pft_tx_s;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] data;
    } pft_rx_s;

    typedef struct packed {
        logic speed_100;
        logic an_en;
    } pft_strap_s;

endpackage

// file: tb/pft_phy_timing_properties.sv
// Port-level timing properties of the transceiver timing block.
// Assumes it is bound to pft_phy_timing and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pft_phy_timing_properties (
    // Clock and reset.
    input wire logic                core_clk,
    input wire logic                rst,
    // Configuration.
    input wire pft_pkg::pft_strap_s cfg,
    input wire logic                cfg_loaded,
    // MAC and line side.
    input wire logic                mii_txc,
    input wire logic                mii_rxc,
    input wire pft_pkg::pft_tx_s    mii_tx,
    input wire pft_pkg::pft_rx_s    mii_rx,
    input wire logic                mii_crs,
    input wire pft_pkg::pft_tx_s    line_tx,
    input wire logic                line_tx_stb,
    input wire logic                line_rx_carrier,
    input wire logic                flp_pulse
);
    import pft_pkg::*;
    logic [11:0] gap_q;
    logic [11:0] gap_d;
    logic        f10;
    logic        f100;
    // The gap count saturates so quiet time between bursts stays cheap.
    always_comb begin
        gap_d = flp_pulse ? 12'h001 : gap_q + {11'h000, ~&gap_q};
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 12'hFFF;
        end else begin
            gap_q <= gap_d;
        end
    end
    assign f10  = cfg_loaded && !cfg.speed_100;
    assign f100 = cfg_loaded && cfg.speed_100;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    clk_slow_a: assert property (
        $rose(mii_txc) && f10 |=> mii_txc ##1 !mii_txc) else $error("slow");
    clk_fast_a: assert property (
        $rose(mii_txc) && f100 && $past(cfg_loaded, 4) |=> !mii_txc ##1
        mii_txc) else $error("fast clock phase");
    rx_clock_a: assert property (
        mii_rxc == mii_txc) else $error("rx clock");
    tx_strobe_a: assert property (
        line_tx_stb == $rose(mii_txc)) else $error("tx strobe");
    tx_take_a: assert property (
        line_tx_stb |-> line_tx == $past(mii_tx, 3)) else $error("tx take");
    rx_edge_a: assert property (
        $changed(mii_rx) |-> $rose(mii_rxc)) else $error("rx edge");
    crs_on_a: assert property (
        $rose(line_tx.en) && f10 && !line_rx_carrier |-> ##5 !mii_crs ##1
        mii_crs) else $error("crs on");
    crs_off_a: assert property (
        $fell(line_tx.en) && f10 && !line_rx_carrier |-> ##9 mii_crs ##1
        !mii_crs) else $error("crs off");
    rx_late_a: assert property (
        $rose(line_rx_carrier) && f10 && !mii_rx.dv |-> ##[70:80]
        $rose(mii_rx.dv)) else $error("rx latency");
    flp_wide_a: assert property (
        flp_pulse |=> !flp_pulse) else $error("pulse width");
    flp_gap_a: assert property (
        flp_pulse && gap_q < 12'h7D0 |-> gap_q == 12'h280 ||
        gap_q == 12'h500) else $error("pulse gap");
    cover property (f100 && line_tx_stb && line_tx.en);
    cover property (f10 && $rose(mii_rx.dv));
    cover property (flp_pulse && gap_q == 12'h280);
endmodule
bind pft_phy_timing pft_phy_timing_properties u_props (.*);
`default_nettype wire

// file: tb/pft_mac_model.sv
// MAC stand-in that drives transmit nibbles after each transmit clock rise.
// Assumes the core clock and the transmit clock that the block sources.
`timescale 1ns/1ps
`default_nettype none
module pft_mac_model (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Transmit side.
    input  wire logic             mii_txc,
    input  wire logic             send,
    output var  pft_pkg::pft_tx_s mii_tx
);
    import pft_pkg::*;
    logic seen = 1'b0;
    logic rise;
    logic clr;
    logic want;
    // Data always changes, so a stale nibble can never pass for a new one.
    // Reset and send are taken at the edge, so the late update never races
    // the bench, and a MAC held in reset stops driving nibbles.
    always @(posedge core_clk) begin
        rise = mii_txc && !seen && !rst;
        clr  = rst;
        want = send;
        seen = mii_txc;
        #1;
        if (clr) begin
            mii_tx = '0;
        end else if (rise) begin
            mii_tx.en   = want;
            mii_tx.data = mii_tx.data ^ 4'(1 + $urandom_range(14));
        end
    end
endmodule
`default_nettype wire

// file: tb/pft_phy_timing_tb_top.sv
// Self-checking bench for the transceiver timing block.
// Assumes the MAC model and the bound property checker.
`timescale 1ns/1ps
`default_nettype none
module pft_phy_timing_tb_top;
    import pft_pkg::*;
    localparam int unsigned BTB  = 30000;
    localparam logic [15:0] WORD = 16'hA5C3;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       send = 1'b0;
    logic       line_rx_carrier = 1'b0;
    logic [3:0] line_rx_data = 4'h0;
    logic       line_rx_err = 1'b0;
    pft_strap_s strap_pins = '0;
    pft_strap_s cfg;
    pft_tx_s    mii_tx, line_tx, tx_now, tx_old;
    pft_rx_s    mii_rx, rx_old;
    logic       cfg_loaded, mii_txc, mii_rxc, mii_crs, line_tx_stb;
    logic       flp_pulse, spd, rxc_old;
    int         n_mismatch = 0, n_tests = 0, n, m, lat;
    int         quiet, since, n_pulse, n_burst;
    pft_phy_timing #(.FLP_BTB_CYC(BTB), .FLP_WORD(WORD)) dut (.core_clk,
        .rst, .strap_pins, .cfg, .cfg_loaded, .mii_txc, .mii_rxc, .mii_tx,
        .mii_rx, .mii_crs, .line_tx, .line_tx_stb, .line_rx_carrier,
        .line_rx_data, .line_rx_err, .flp_pulse);
    pft_mac_model mac (.core_clk, .rst, .mii_txc, .send, .mii_tx);
    initial forever #50 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return mii_crs;
            1: return mii_rx.dv;
            2: return cfg_loaded;
            3: return line_tx.en;
            default: return mii_txc;
        endcase
    endfunction
    task automatic wait_on(input int w, input logic v, output int k);
        k = 0;
        while (pick(w) !== v && k < 300) begin
            tick();
            k++;
        end
        if (k >= 300) begin
            $display("unexpected at %0t: wait timed out", $time);
            n_mismatch++;
            wrap_up();
        end
    endtask
    always @(posedge core_clk) begin
        #1;
        line_rx_data = 4'($urandom);
        line_rx_err  = 1'($urandom);
    end
    always @(posedge core_clk) begin
        if (cfg_loaded && line_tx_stb) chk(line_tx, spd ? tx_old : mii_tx);
        if (mii_rxc && !rxc_old && mii_rx.dv) chk(mii_rx, rx_old);
        if (mii_tx !== tx_now) begin
            tx_old = tx_now;
            tx_now = mii_tx;
        end
        rxc_old = mii_rxc;
        rx_old  = {1'b1, line_rx_err, line_rx_data};
    end
    always @(posedge core_clk) begin
        if (rst) begin
            quiet   = 9999;
            n_burst = 0;
            n_pulse = 0;
            since   = 0;
        end else begin
            since++;
            quiet++;
            if (flp_pulse && quiet > 2000) begin
                if (n_burst > 0) chk(n_pulse, 17 + $countones(WORD));
                if (n_burst > 0) chk(since, BTB);
                n_burst++;
                n_pulse = 0;
                since   = 0;
            end
            if (flp_pulse) begin
                n_pulse++;
                quiet = 0;
            end
        end
    end
    initial begin
        void'($urandom(32'h0123BE6B));
        for (int p = 0; p < 2; p++) begin
            spd        = p[0];
            strap_pins = {p[0], ~p[0]};
            rst        = 1'b1;
            repeat (3) tick();
            rst = 1'b0;
            wait_on(2, 1'b1, n);
            chk(n, 3);
            chk(cfg, {spd, ~spd});
            strap_pins = ~strap_pins;
            repeat (4) tick();
            chk(cfg, {spd, ~spd});
            wait_on(4, 1'b0, n);
            wait_on(4, 1'b1, n);
            wait_on(4, 1'b0, n);
            wait_on(4, 1'b1, m);
            chk(n + m, spd ? 2 : 4);
            chk(mii_rxc, mii_txc);
            repeat (3) begin
                send = 1'b1;
                wait_on(3, 1'b1, n);
                wait_on(0, 1'b1, n);
                chk(n, spd ? PFT_CRS_100_CYC : PFT_CRS_ON10_CYC);
                repeat (8 + $urandom_range(24)) tick();
                send = 1'b0;
                wait_on(3, 1'b0, n);
                wait_on(0, 1'b0, n);
                chk(n, spd ? PFT_CRS_100_CYC : PFT_CRS_OFF10_CYC);
                line_rx_carrier = 1'b1;
                wait_on(1, 1'b1, n);
                lat = spd ? PFT_RXLAT100_CYC : PFT_RXLAT10_CYC;
                chk(n > lat && n <= lat + 6, 1'b1);
                repeat (16 + $urandom_range(16)) tick();
                line_rx_carrier = 1'b0;
                wait_on(1, 1'b0, n);
                wait_on(0, 1'b0, n);
            end
            if (!spd) repeat (33000) tick();
        end
        wrap_up();
    end
endmodule
`default_nettype wire
